// file: hdl/cskp_pkg.sv
package cskp_pkg;

   // Instruction word fields
   localparam int OP_MSB = 15;
   localparam int OP_LSB = 9;
   localparam int ACC_BIT = 8;
   localparam int F_MSB = 7;

   localparam logic [6:0] OP_EQUAL = 7'h31;   // 0110 001
   localparam logic [6:0] OP_GREATER = 7'h32; // 0110 010
   localparam logic [6:0] OP_LESS = 7'h30;    // 0110 000

   // Data memory map
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [7:0] INDEXED_MAX = 8'h5f;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

   // Quarter phases of one instruction cycle
   localparam logic [1:0] PH_Q1 = 2'h0;
   localparam logic [1:0] PH_Q2 = 2'h1;
   localparam logic [1:0] PH_Q3 = 2'h2;
   localparam logic [1:0] PH_Q4 = 2'h3;

   localparam logic [1:0] SKIP_ONE = 2'h1;
   localparam logic [1:0] SKIP_TWO = 2'h2;

   typedef enum logic [1:0] {
      CMP_NONE,
      CMP_EQUAL,
      CMP_GREATER,
      CMP_LESS
   } cskp_kind_e;

   typedef struct packed {
      cskp_kind_e kind;
      logic access_b;
      logic [7:0] faddr;
   } cskp_dec_s;

   typedef struct packed {
      logic rd;
      logic indexed;
      logic [11:0] addr;
   } cskp_mem_req_s;

endpackage : cskp_pkg

// file: hdl/cskp_top.sv
`timescale 1ns/1ps
module cskp_top (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic next_two_word,
   input wire logic [7:0] working_accumulator,
   input wire logic [3:0] bank_select_register,
   input wire logic ext_set_en,
   input wire logic [11:0] index_base,
   input wire logic [7:0] mem_rdata,
   output logic [1:0] q_phase_q,
   output cskp_pkg::cskp_mem_req_s mem_req_q,
   output logic exec_q,
   output logic skip_q,
   output logic discard_q,
   output logic result_we_q
);

   typedef enum logic [1:0] {ST_RUN, ST_EXEC, ST_SKIP} cskp_state_e;

   logic rst_meta_q;
   logic rst_sync_b_q;
   cskp_state_e state_q;
   cskp_pkg::cskp_dec_s dec_q;
   cskp_pkg::cskp_dec_s dec_d;
   logic [7:0] data_q;
   logic [1:0] skip_left_q;
   logic [8:0] diff;
   logic hit;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_q <= 1'b0;
         rst_sync_b_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_b_q <= rst_meta_q;
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_b_q) begin
      if (!rst_sync_b_q) begin
         q_phase_q <= cskp_pkg::PH_Q1;
      end else begin
         q_phase_q <= q_phase_q + 2'h1;
      end
   end

   always_comb begin
      dec_d.access_b = instr_word[cskp_pkg::ACC_BIT];
      dec_d.faddr = instr_word[cskp_pkg::F_MSB:0];
      unique case (instr_word[cskp_pkg::OP_MSB:cskp_pkg::OP_LSB])
         cskp_pkg::OP_EQUAL: dec_d.kind = cskp_pkg::CMP_EQUAL;
         cskp_pkg::OP_GREATER: dec_d.kind = cskp_pkg::CMP_GREATER;
         cskp_pkg::OP_LESS: dec_d.kind = cskp_pkg::CMP_LESS;
         default: dec_d.kind = cskp_pkg::CMP_NONE;
      endcase
   end

   // Only borrow and zero leave the subtractor; no flag or file is written
   assign diff = {1'b0, data_q} - {1'b0, working_accumulator};

   always_comb begin
      unique case (dec_q.kind)
         cskp_pkg::CMP_EQUAL: hit = (diff[7:0] == 8'h00);
         cskp_pkg::CMP_GREATER: hit = !diff[8] && (diff[7:0] != 8'h00);
         cskp_pkg::CMP_LESS: hit = diff[8];
         default: hit = 1'b0;
      endcase
   end

   // Instruction sequencing; a compare is taken at Q1, then advanced at the Q4 boundary
   always_ff @(posedge core_clk or negedge rst_sync_b_q) begin
      if (!rst_sync_b_q) begin
         state_q <= ST_RUN;
         dec_q <= '0;
         skip_left_q <= 2'h0;
      end else begin
         unique case (state_q)
            ST_RUN: begin
               if (q_phase_q == cskp_pkg::PH_Q1 && instr_valid &&
                   dec_d.kind != cskp_pkg::CMP_NONE) begin
                  dec_q <= dec_d;
                  state_q <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               if (q_phase_q == cskp_pkg::PH_Q4) begin
                  if (skip_q) begin
                     state_q <= ST_SKIP;
                     skip_left_q <= next_two_word ? cskp_pkg::SKIP_TWO
                                                  : cskp_pkg::SKIP_ONE;
                  end else begin
                     state_q <= ST_RUN;
                  end
                  dec_q <= '0;
               end
            end
            ST_SKIP: begin
               if (q_phase_q == cskp_pkg::PH_Q4) begin
                  skip_left_q <= skip_left_q - 2'h1;
                  if (skip_left_q == cskp_pkg::SKIP_ONE) begin
                     state_q <= ST_RUN;
                  end
               end
            end
            default: state_q <= ST_RUN;
         endcase
      end
   end

   // Address resolution; the memory answers in the same cycle as the request
   always_ff @(posedge core_clk or negedge rst_sync_b_q) begin
      if (!rst_sync_b_q) begin
         mem_req_q <= '0;
      end else if (state_q == ST_RUN && q_phase_q == cskp_pkg::PH_Q1 &&
                   instr_valid && dec_d.kind != cskp_pkg::CMP_NONE) begin
         // Issued from the Q1 decode so the read stands through Q2
         mem_req_q.rd <= 1'b1;
         mem_req_q.indexed <= 1'b0;
         if (dec_d.access_b) begin
            mem_req_q.addr <= {bank_select_register, dec_d.faddr};
         end else if (ext_set_en && dec_d.faddr <= cskp_pkg::INDEXED_MAX) begin
            mem_req_q.indexed <= 1'b1;
            mem_req_q.addr <= index_base + {4'h0, dec_d.faddr};
         end else if (dec_d.faddr < cskp_pkg::ACCESS_SPLIT) begin
            mem_req_q.addr <= {cskp_pkg::ACCESS_LOW_BANK, dec_d.faddr};
         end else begin
            mem_req_q.addr <= {cskp_pkg::ACCESS_HIGH_BANK, dec_d.faddr};
         end
      end else begin
         mem_req_q.rd <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_b_q) begin
      if (!rst_sync_b_q) begin
         data_q <= 8'h00;
      end else if (mem_req_q.rd) begin
         data_q <= mem_rdata;
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_b_q) begin
      if (!rst_sync_b_q) begin
         skip_q <= 1'b0;
      end else if (state_q == ST_EXEC && q_phase_q == cskp_pkg::PH_Q3) begin
         skip_q <= hit;
      end else if (q_phase_q == cskp_pkg::PH_Q4) begin
         skip_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_b_q) begin
      if (!rst_sync_b_q) begin
         exec_q <= 1'b0;
         discard_q <= 1'b0;
         result_we_q <= 1'b0;
      end else begin
         exec_q <= (state_q == ST_RUN && q_phase_q == cskp_pkg::PH_Q1 &&
                    instr_valid && dec_d.kind != cskp_pkg::CMP_NONE) ||
                   (state_q == ST_EXEC && q_phase_q != cskp_pkg::PH_Q4);
         discard_q <= (state_q == ST_EXEC && q_phase_q == cskp_pkg::PH_Q4 &&
                       skip_q) ||
                      (state_q == ST_SKIP && !(q_phase_q == cskp_pkg::PH_Q4 &&
                       skip_left_q == cskp_pkg::SKIP_ONE));
         result_we_q <= 1'b0;
      end
   end

   // Checks
   int unsigned disc_cnt_q;
   always_ff @(posedge core_clk or negedge rst_sync_b_q) begin
      if (!rst_sync_b_q) begin
         disc_cnt_q <= 0;
      end else if (discard_q) begin
         disc_cnt_q <= disc_cnt_q + 1;
      end else begin
         disc_cnt_q <= 0;
      end
   end

   property p_eq_skip;
      @(posedge core_clk) disable iff (!rst_sync_b_q)
      (state_q == ST_EXEC && q_phase_q == cskp_pkg::PH_Q3 &&
       dec_q.kind == cskp_pkg::CMP_EQUAL) |=> (skip_q == (data_q ==
       $past(working_accumulator)));
   endproperty
   a_eq_skip: assert property (p_eq_skip) else $error("equal skip wrong");

   property p_gt_skip;
      @(posedge core_clk) disable iff (!rst_sync_b_q)
      (state_q == ST_EXEC && q_phase_q == cskp_pkg::PH_Q3 &&
       dec_q.kind == cskp_pkg::CMP_GREATER) |=> (skip_q == (data_q >
       $past(working_accumulator)));
   endproperty
   a_gt_skip: assert property (p_gt_skip) else $error("greater skip wrong");

   property p_lt_skip;
      @(posedge core_clk) disable iff (!rst_sync_b_q)
      (state_q == ST_EXEC && q_phase_q == cskp_pkg::PH_Q3 &&
       dec_q.kind == cskp_pkg::CMP_LESS) |=> (skip_q == (data_q <
       $past(working_accumulator)));
   endproperty
   a_lt_skip: assert property (p_lt_skip) else $error("less skip wrong");

   property p_no_write;
      @(posedge core_clk) disable iff (!rst_sync_b_q) !result_we_q;
   endproperty
   a_no_write: assert property (p_no_write) else $error("write seen");

   property p_bank;
      @(posedge core_clk) disable iff (!rst_sync_b_q)
      (state_q == ST_RUN && q_phase_q == cskp_pkg::PH_Q1 && instr_valid &&
       dec_d.kind != cskp_pkg::CMP_NONE && dec_d.access_b)
      |=> mem_req_q.rd && mem_req_q.addr == {$past(bank_select_register),
      dec_q.faddr};
   endproperty
   a_bank: assert property (p_bank) else $error("banked address wrong");

   property p_access;
      @(posedge core_clk) disable iff (!rst_sync_b_q)
      (state_q == ST_RUN && q_phase_q == cskp_pkg::PH_Q1 && instr_valid &&
       dec_d.kind != cskp_pkg::CMP_NONE && !dec_d.access_b && !ext_set_en)
      |=> mem_req_q.rd && !mem_req_q.indexed &&
      mem_req_q.addr[7:0] == dec_q.faddr;
   endproperty
   a_access: assert property (p_access) else $error("access address wrong");

   property p_indexed;
      @(posedge core_clk) disable iff (!rst_sync_b_q)
      (state_q == ST_RUN && q_phase_q == cskp_pkg::PH_Q1 && instr_valid &&
       dec_d.kind != cskp_pkg::CMP_NONE && !dec_d.access_b && ext_set_en &&
       dec_d.faddr <= cskp_pkg::INDEXED_MAX)
      |=> mem_req_q.indexed;
   endproperty
   a_indexed: assert property (p_indexed) else $error("indexed missed");

   property p_no_skip_len;
      @(posedge core_clk) disable iff (!rst_sync_b_q)
      (state_q == ST_EXEC && q_phase_q == cskp_pkg::PH_Q4 && !skip_q)
      |=> !discard_q [*4];
   endproperty
   a_no_skip_len: assert property (p_no_skip_len) else $error("stray discard");

   property p_skip_len;
      @(posedge core_clk) disable iff (!rst_sync_b_q)
      $fell(discard_q) |-> ($past(disc_cnt_q) == 3 || $past(disc_cnt_q) == 7);
   endproperty
   a_skip_len: assert property (p_skip_len) else $error("skip length wrong");

   property p_phases;
      @(posedge core_clk) disable iff (!rst_sync_b_q)
      $rose(mem_req_q.rd) |-> q_phase_q == cskp_pkg::PH_Q2 ##1
      (!mem_req_q.rd && q_phase_q == cskp_pkg::PH_Q3);
   endproperty
   a_phases: assert property (p_phases) else $error("read not in Q2");

endmodule : cskp_top

// file: bench/tb_compare_skip_instructions.sv
`timescale 1ns/1ps
module tb_compare_skip_instructions;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic instr_valid = 1'b0;
   logic [15:0] instr_word = 16'h0000;
   logic next_two_word = 1'b0;
   logic [7:0] working_accumulator = 8'h00;
   logic [3:0] bank_select_register = 4'h0;
   logic ext_set_en = 1'b0;
   logic [11:0] index_base = 12'hfb0;
   logic [7:0] mem_rdata = 8'h00;
   logic [1:0] q_phase_q;
   cskp_pkg::cskp_mem_req_s mem_req_q;
   logic exec_q;
   logic skip_q;
   logic discard_q;
   logic result_we_q;
   int num_errors = 0;
   int n_compared = 0;

   cskp_top DUT (
      .core_clk(core_clk), .rst_b(rst_b), .instr_valid(instr_valid),
      .instr_word(instr_word), .next_two_word(next_two_word),
      .working_accumulator(working_accumulator),
      .bank_select_register(bank_select_register), .ext_set_en(ext_set_en),
      .index_base(index_base), .mem_rdata(mem_rdata), .q_phase_q(q_phase_q),
      .mem_req_q(mem_req_q), .exec_q(exec_q), .skip_q(skip_q),
      .discard_q(discard_q), .result_we_q(result_we_q)
   );

   always #2 core_clk = ~core_clk;

   task automatic chk(input string name, input logic [15:0] exp,
                      input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic finish_test();
      $display("errors %0d compares %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test

   // One instruction cycle of a compare; also used for a refused opcode
   task automatic run_cmp(input logic [6:0] op, input logic acc,
                          input logic [7:0] f, input logic [7:0] w,
                          input logic [7:0] data, input logic two,
                          input logic [3:0] bank, input logic ext);
      logic ex;
      logic skp;
      logic idx;
      logic [11:0] ea;
      int n;
      ex = (op == cskp_pkg::OP_EQUAL) || (op == cskp_pkg::OP_GREATER) ||
           (op == cskp_pkg::OP_LESS);
      skp = (op == cskp_pkg::OP_EQUAL && data == w) ||
            (op == cskp_pkg::OP_GREATER && data > w) ||
            (op == cskp_pkg::OP_LESS && data < w);
      idx = !acc && ext && f <= 8'h5f;
      ea = acc ? {bank, f} : idx ? index_base + {4'h0, f} :
           (f < 8'h60) ? {4'h0, f} : {4'hf, f};
      do @(negedge core_clk); while (q_phase_q !== 2'h0);
      instr_valid = 1'b1;
      instr_word = {op, acc, f};
      working_accumulator = w;
      mem_rdata = data;
      next_two_word = two;
      bank_select_register = bank;
      ext_set_en = ext;
      @(negedge core_clk);
      instr_valid = 1'b0;
      bank_select_register = ~bank;
      chk("exec", {15'h0, ex}, {15'h0, exec_q});
      chk("rd", {15'h0, ex}, {15'h0, mem_req_q.rd});
      chk("discard", 16'h0, {15'h0, discard_q});
      if (ex) begin
         chk("addr", {4'h0, ea}, {4'h0, mem_req_q.addr});
         chk("indexed", {15'h0, idx}, {15'h0, mem_req_q.indexed});
      end
      @(negedge core_clk);
      mem_rdata = ~data;
      chk("rd_q3", 16'h0, {15'h0, mem_req_q.rd});
      @(negedge core_clk);
      chk("skip", {15'h0, skp}, {15'h0, skip_q});
      chk("exec_q4", {15'h0, ex}, {15'h0, exec_q});
      chk("we", 16'h0, {15'h0, result_we_q});
      working_accumulator = ~w;
      if (skp) begin
         n = 0;
         repeat (9) begin
            @(negedge core_clk);
            n += int'(discard_q === 1'b1);
            chk("we_skip", 16'h0, {15'h0, result_we_q});
         end
         chk("discard_len", two ? 16'h8 : 16'h4, n[15:0]);
      end
   endtask : run_cmp

   initial begin
      repeat (8) @(negedge core_clk);
      chk("rst_exec", 16'h0, {15'h0, exec_q});
      chk("rst_phase", 16'h0, {14'h0, q_phase_q});
      rst_b = 1'b1;
      // Let the reset synchroniser release before the first word
      repeat (3) @(negedge core_clk);
      // Equal hit skipping one word, then a miss, then a hit skipping a two-word instruction
      run_cmp(cskp_pkg::OP_EQUAL, 1'b1, 8'h12, 8'h5a, 8'h5a, 1'b0,
              4'h3, 1'b0);
      run_cmp(cskp_pkg::OP_EQUAL, 1'b1, 8'hff, 8'h5a, 8'h5b, 1'b0,
              4'hc, 1'b0);
      run_cmp(cskp_pkg::OP_EQUAL, 1'b1, 8'h00, 8'h5a, 8'h5a, 1'b1,
              4'h1, 1'b0);
      // Unsigned order: 0x80 is above 0x7f
      run_cmp(cskp_pkg::OP_GREATER, 1'b0, 8'h5f, 8'h7f, 8'h80, 1'b0,
              4'h2, 1'b0);
      run_cmp(cskp_pkg::OP_GREATER, 1'b0, 8'h60, 8'h40, 8'h40, 1'b0,
              4'h2, 1'b0);
      run_cmp(cskp_pkg::OP_LESS, 1'b0, 8'h5f, 8'h80, 8'h7f, 1'b1,
              4'h5, 1'b1);
      run_cmp(cskp_pkg::OP_LESS, 1'b0, 8'h60, 8'h80, 8'h80, 1'b0,
              4'h5, 1'b1);
      run_cmp(cskp_pkg::OP_LESS, 1'b1, 8'h10, 8'h01, 8'h00, 1'b0,
              4'ha, 1'b1);
      // Neighbouring opcodes are not compares
      run_cmp(7'h33, 1'b1, 8'h10, 8'h01, 8'h01, 1'b0, 4'h0, 1'b0);
      run_cmp(7'h2f, 1'b0, 8'h10, 8'h01, 8'h01, 1'b0, 4'h0, 1'b0);
      finish_test();
   end

   initial begin
      #20000;
      num_errors++;
      finish_test();
   end
endmodule : tb_compare_skip_instructions
